// ===== hw/charger_irq_mask_status_ctrl_regs.sv
// Purpose: flag, mask, live status and run control registers of the charger
// Assumes: serial engine on link_clk issues one access at a time on the reg_ port
// Notes:   accesses cross to core_clk by a toggle handshake; analog levels pass 3 flops
//
// Contract
// RQ1 - fault_event_mask at 0x03 masks eight abnormal events, resets to 0x03
// RQ2 - mask bit 0 lets its event interrupt, 1 suppresses it
// RQ3 - charge_event_mask at 0x04 masks eight charge events, resets to 0xb8
// RQ4 - rail_event_mask at 0x05 masks four rail events, resets 0xff, writes ones to 7:4
// RQ5 - live_condition 0x06 read-only; bit 4 shows rail overload with valid input
// RQ6 - live_condition bit 3 shows discharge current limit detected
// RQ7 - live_condition bit 2 shows die temperature in thermal shutdown band
// RQ8 - live_condition bit 1 shows battery attached
// RQ9 - live_condition bit 0 shows suspend enabled
// RQ10 - live_condition bits 7:5 reserved, carry no meaning
// RQ11 - run_control 0x07 bit 6 turns comparators on; register resets to 0x42
// RQ12 - writing 1 to run_control bit 3 resets charge parameters only
// RQ13 - software reset bit clears itself, reads back zero
// RQ14 - run_control bit 2 enables suspend, opening input pass switch; default 0
// RQ15 - bit 0 enables boost otg (default 0), bit 1 enables charger (default 1)
// RQ16 - event flags latch on detection, clear when their register is read
// RQ17 - with valid input, comparator events report regardless of comparator enable
// RQ18 - interrupt asserts while any latched flag is unmasked; masked flags still latch
// RQ19 - rail undervoltage returns mask and control registers to defaults
// RQ20 - software writes 0 to run_control bits 7, 5 and 4
module charger_irq_mask_status_ctrl_regs
  import charger_regs_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       resetn,
  input  wire logic       link_clk,
  input  wire logic       link_resetn,
  // register access from the serial engine, link_clk domain
  input  wire logic       reg_start,
  input  wire logic       reg_write,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic            reg_busy,
  output logic            reg_done,
  output logic [7:0]      reg_rdata,
  // analog event levels, asynchronous
  input  wire logic [7:0] fault_events,
  input  wire logic [7:0] charge_events,
  input  wire logic [3:0] rail_events,
  input  wire logic       rail_overload_flag,
  input  wire logic       discharge_limit_flag,
  input  wire logic       thermal_shutdown_flag,
  input  wire logic       battery_present_flag,
  input  wire logic       input_supply_valid,
  input  wire logic       system_rail_uvlo,
  // control outputs, core_clk domain
  output logic            comparator_enable,
  output logic            suspend_enable,
  output logic            charger_enable,
  output logic            boost_otg_enable,
  output logic            charge_param_reset,
  output logic            chg_int
);
  localparam int n_in = 26;

  // link side: hold the request stable while busy, toggle to announce it
  logic       req_tgl_q;
  logic       busy_q;
  logic       done_q;
  logic       write_q;
  logic [7:0] addr_q;
  logic [7:0] wdata_q;
  logic [7:0] rdata_link_q;
  logic [sync_stages-1:0] ack_sync_q;
  logic       ack_seen;
  // core side state read across the boundary or before its own process
  logic       ack_tgl_q;
  logic [7:0] rdata_core_q;
  logic [7:0] ctrl_q;
  logic       comp_pass;

  assign ack_seen = (ack_sync_q[1] == ack_sync_q[2]) && (ack_sync_q[2] == req_tgl_q);

  // ack toggle enters link domain through three flops
  always_ff @(posedge link_clk)
  begin
    if (!link_resetn)
      ack_sync_q <= '0;
    else
      ack_sync_q <= {ack_sync_q[1:0], ack_tgl_q};
  end

  // request capture and completion; starts while busy are ignored
  always_ff @(posedge link_clk)
  begin
    if (!link_resetn)
    begin
      req_tgl_q    <= 1'b0;
      busy_q       <= 1'b0;
      done_q       <= 1'b0;
      write_q      <= 1'b0;
      addr_q       <= 8'h00;
      wdata_q      <= 8'h00;
      rdata_link_q <= 8'h00;
    end
    else
    begin
      done_q <= 1'b0;
      if (!busy_q && reg_start)
      begin
        busy_q    <= 1'b1;
        req_tgl_q <= ~req_tgl_q;
        write_q   <= reg_write;
        addr_q    <= reg_addr;
        wdata_q   <= reg_wdata;
      end
      else if (busy_q && ack_seen)
      begin
        busy_q       <= 1'b0;
        done_q       <= 1'b1;
        rdata_link_q <= rdata_core_q; // stable since the edge that toggled ack
      end
    end
  end

  assign reg_busy  = busy_q;
  assign reg_done  = done_q;
  assign reg_rdata = rdata_link_q;

  // core side: request toggle and all analog levels through three flops
  logic [sync_stages-1:0] req_sync_q;
  logic                   req_last_q;
  logic                   new_req;
  logic [n_in-1:0]        in_s1_q;
  logic [n_in-1:0]        in_s2_q;
  logic [n_in-1:0]        in_s3_q;
  logic [n_in-1:0]        in_stable_q;
  logic [n_in-1:0]        in_raw;

  assign in_raw = {system_rail_uvlo, input_supply_valid, rail_overload_flag,
                   discharge_limit_flag, thermal_shutdown_flag, battery_present_flag,
                   rail_events, charge_events, fault_events};
  assign new_req = (req_sync_q[1] == req_sync_q[2]) && (req_sync_q[2] != req_last_q);

  // a level is taken only once the second and third stages agree
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      req_sync_q  <= '0;
      in_s1_q     <= '0;
      in_s2_q     <= '0;
      in_s3_q     <= '0;
      in_stable_q <= '0;
    end
    else
    begin
      req_sync_q <= {req_sync_q[1:0], req_tgl_q};
      in_s1_q    <= in_raw;
      in_s2_q    <= in_s1_q;
      in_s3_q    <= in_s2_q;
      for (int i = 0; i < n_in; i++)
        if (in_s2_q[i] == in_s3_q[i])
          in_stable_q[i] <= in_s3_q[i];
    end
  end

  logic [19:0] ev_level;
  logic [19:0] ev_rise;
  logic        uvlo;
  logic        vin_ok;
  logic [3:0]  live_bits;

  assign uvlo      = in_stable_q[25];
  assign vin_ok    = in_stable_q[24];
  assign live_bits = in_stable_q[23:20];
  assign ev_level  = in_stable_q[19:0];

  // event edges; comparator events pass if comparators on or input valid
  always_comb
  begin
    ev_rise = '0;
    for (int i = 0; i < 20; i++)
      ev_rise[i] = (in_s2_q[i] == in_s3_q[i]) && in_s3_q[i] && !ev_level[i]; // RQ16
    ev_rise[7:0]   = ev_rise[7:0]   & (~fault_comp_events  | {8{comp_pass}});
    ev_rise[15:8]  = ev_rise[15:8]  & (~charge_comp_events | {8{comp_pass}});
    ev_rise[19:16] = ev_rise[19:16] & (~rail_comp_events   | {4{comp_pass}});
  end

  assign comp_pass = ctrl_q[comparator_enable_bit] | vin_ok; // RQ11 RQ17

  // registers
  logic [7:0] fault_flag_q;
  logic [7:0] charge_flag_q;
  logic [3:0] rail_flag_q;
  logic [7:0] fault_mask_q;
  logic [7:0] charge_mask_q;
  logic [7:0] rail_mask_q;
  logic       soft_rst_q;
  logic       rd_now;
  logic       wr_now;
  logic [7:0] rd_value;

  assign rd_now = new_req && !write_q;
  assign wr_now = new_req && write_q;

  // read multiplexer; unmapped offsets read zero
  always_comb
  begin
    unique case (addr_q)
      fault_flag_off:        rd_value = fault_flag_q;
      charge_flag_off:       rd_value = charge_flag_q;
      rail_flag_off:         rd_value = {4'h0, rail_flag_q};
      fault_event_mask_off:  rd_value = fault_mask_q;
      charge_event_mask_off: rd_value = charge_mask_q;
      rail_event_mask_off:   rd_value = rail_mask_q;
      live_condition_off:    rd_value = {3'h0, live_bits, ctrl_q[suspend_enable_bit]}; // RQ5 RQ6 RQ7 RQ8 RQ9 RQ10
      run_control_off:       rd_value = ctrl_q & run_control_keep; // RQ13
      default:               rd_value = 8'h00;
    endcase
  end

  // answer: capture read data and toggle ack back to the link side on the same edge
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      req_last_q   <= 1'b0;
      ack_tgl_q    <= 1'b0;
      rdata_core_q <= 8'h00;
    end
    else if (new_req)
    begin
      req_last_q   <= req_sync_q[2];
      ack_tgl_q    <= req_sync_q[2];
      rdata_core_q <= rd_value;
    end
  end

  // flags: detection wins over the clear caused by a read in the same cycle
  always_ff @(posedge core_clk)
  begin
    if (!resetn || uvlo)
    begin
      fault_flag_q  <= 8'h00;
      charge_flag_q <= 8'h00;
      rail_flag_q   <= 4'h0;
    end
    else
    begin
      fault_flag_q  <= (fault_flag_q & ~{8{rd_now && addr_q == fault_flag_off}})
                       | ev_rise[7:0]; // RQ16
      charge_flag_q <= (charge_flag_q & ~{8{rd_now && addr_q == charge_flag_off}})
                       | ev_rise[15:8]; // RQ16
      rail_flag_q   <= (rail_flag_q & ~{4{rd_now && addr_q == rail_flag_off}})
                       | ev_rise[19:16]; // RQ16
    end
  end

  // masks; reserved rail mask bits are stored as written
  always_ff @(posedge core_clk)
  begin
    if (!resetn || uvlo) // RQ19
    begin
      fault_mask_q  <= fault_event_mask_rst; // RQ1
      charge_mask_q <= charge_event_mask_rst; // RQ3
      rail_mask_q   <= rail_event_mask_rst; // RQ4
    end
    else if (wr_now)
    begin
      if (addr_q == fault_event_mask_off)
        fault_mask_q <= wdata_q; // RQ1
      if (addr_q == charge_event_mask_off)
        charge_mask_q <= wdata_q; // RQ3
      if (addr_q == rail_event_mask_off)
        rail_mask_q <= wdata_q; // RQ4
    end
  end

  // run control; unimplemented bits are dropped so they read zero
  always_ff @(posedge core_clk)
  begin
    if (!resetn || uvlo) // RQ19
      ctrl_q <= run_control_rst; // RQ11 RQ14 RQ15
    else if (wr_now && addr_q == run_control_off)
      ctrl_q <= wdata_q & run_control_keep & ~(8'h01 << soft_reset_bit); // RQ20
  end

  // software reset: one-cycle pulse to the charge parameter bank only
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
      soft_rst_q <= 1'b0;
    else
      soft_rst_q <= wr_now && addr_q == run_control_off && wdata_q[soft_reset_bit]; // RQ12 RQ13
  end

  // interrupt: unmasked latched flags only, masked ones stay latched
  logic int_q;
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
      int_q <= 1'b0;
    else
      int_q <= |(fault_flag_q & ~fault_mask_q) | |(charge_flag_q & ~charge_mask_q)
               | |(rail_flag_q & ~rail_mask_q[3:0]); // RQ2 RQ18
  end

  assign comparator_enable  = ctrl_q[comparator_enable_bit]; // RQ11
  assign suspend_enable     = ctrl_q[suspend_enable_bit]; // RQ14
  assign charger_enable     = ctrl_q[charger_enable_bit]; // RQ15
  assign boost_otg_enable   = ctrl_q[boost_otg_enable_bit]; // RQ15
  assign charge_param_reset = soft_rst_q;
  assign chg_int            = int_q;
endmodule : charger_irq_mask_status_ctrl_regs

// ===== hw/charger_regs_pkg.sv
// Purpose: constants shared by the charger mask/status/control register bank
// Assumes: 8-bit register offsets and 8-bit register data
// Notes:   flag registers sit below the mask registers at the low offsets
package charger_regs_pkg;
  localparam logic [7:0] fault_flag_off        = 8'h00;
  localparam logic [7:0] charge_flag_off       = 8'h01;
  localparam logic [7:0] rail_flag_off         = 8'h02;
  localparam logic [7:0] fault_event_mask_off  = 8'h03;
  localparam logic [7:0] charge_event_mask_off = 8'h04;
  localparam logic [7:0] rail_event_mask_off   = 8'h05;
  localparam logic [7:0] live_condition_off    = 8'h06;
  localparam logic [7:0] run_control_off       = 8'h07;

  localparam logic [7:0] fault_event_mask_rst  = 8'h03;
  localparam logic [7:0] charge_event_mask_rst = 8'hb8;
  localparam logic [7:0] rail_event_mask_rst   = 8'hff;
  localparam logic [7:0] run_control_rst       = 8'h42;

  // run_control fields
  localparam int comparator_enable_bit = 6;
  localparam int soft_reset_bit        = 3;
  localparam int suspend_enable_bit    = 2;
  localparam int charger_enable_bit    = 1;
  localparam int boost_otg_enable_bit  = 0;
  // bits software may hold in run_control; 7, 5, 4 read as zero
  localparam logic [7:0] run_control_keep = 8'h47;

  // events that depend on the comparators
  localparam logic [7:0] fault_comp_events  = 8'h04;
  localparam logic [7:0] charge_comp_events = 8'h20;
  localparam logic [3:0] rail_comp_events   = 4'hd;

  localparam int sync_stages = 3;
endpackage : charger_regs_pkg

// ===== sim/charger_regs_chk_sva.sv
// Purpose: port checks for the charger register bank
// Assumes: both resets active low and synchronous
// Notes:   uvlo windows allow three sync flops, the stable stage and one register for controls, two for the interrupt
module charger_regs_chk
(
  input logic       core_clk,
  input logic       resetn,
  input logic       link_clk,
  input logic       link_resetn,
  input logic       reg_start,
  input logic       reg_busy,
  input logic       reg_done,
  input logic [7:0] reg_rdata,
  input logic       system_rail_uvlo,
  input logic       comparator_enable,
  input logic       suspend_enable,
  input logic       charger_enable,
  input logic       boost_otg_enable,
  input logic       charge_param_reset,
  input logic       chg_int
);
  timeunit 1ns;
  timeprecision 1ns;
  // link side handshake
  a_start_sets_busy: assert property (@(posedge link_clk) disable iff (!link_resetn)
    reg_start && !reg_busy |=> reg_busy && !reg_done) else $error("busy missing after start");
  a_done_ends_busy: assert property (@(posedge link_clk) disable iff (!link_resetn)
    reg_done |-> !reg_busy ##1 !reg_done) else $error("done not a lone pulse");
  a_busy_bounded: assert property (@(posedge link_clk) disable iff (!link_resetn)
    $rose(reg_busy) |-> ##[3:12] reg_done) else $error("access never answered");
  a_rdata_holds: assert property (@(posedge link_clk) disable iff (!link_resetn)
    !reg_done |-> $stable(reg_rdata)) else $error("read data moved without done");
  // core side control effects
  a_param_pulse: assert property (@(posedge core_clk) disable iff (!resetn)
    charge_param_reset |=> !charge_param_reset) else $error("soft reset stuck high");
  a_param_needs_write: assert property (@(posedge core_clk) disable iff (!resetn)
    $rose(charge_param_reset) |-> reg_busy) else $error("soft reset with no access");
  a_uvlo_defaults: assert property (@(posedge core_clk) disable iff (!resetn)
    system_rail_uvlo [*6] |-> comparator_enable && charger_enable && !suspend_enable
    && !boost_otg_enable) else $error("controls not at defaults in uvlo");
  a_uvlo_int_low: assert property (@(posedge core_clk) disable iff (!resetn)
    system_rail_uvlo [*8] |-> !chg_int) else $error("interrupt high in uvlo");
  a_ctrl_needs_access: assert property (@(posedge core_clk) disable iff (!resetn)
    $changed({comparator_enable, suspend_enable, charger_enable, boost_otg_enable})
    |-> reg_busy || system_rail_uvlo) else $error("control moved on its own");
endmodule : charger_regs_chk

bind charger_irq_mask_status_ctrl_regs charger_regs_chk charger_regs_chk_inst (.*);

// ===== sim/link_master.sv
// Purpose: serial engine stand-in on the link side register port
// Assumes: one access at a time, started after the previous done
// Notes:   address and data are inverted after the answer so stale values never look valid
module link_master
(
  input  wire logic       link_clk,
  input  wire logic       reg_done,
  input  wire logic [7:0] reg_rdata,
  output logic            reg_start,
  output logic            reg_write,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  int timeouts = 0;
  // idle port at time zero
  initial
  begin
    reg_start = 1'b0;
    reg_write = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end
  // one access; start is a single cycle pulse, answer bounded at 40 link cycles
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q);
    int n;
    @(posedge link_clk);
    #1;
    reg_start = 1'b1;
    reg_write = wr;
    reg_addr  = a;
    reg_wdata = d;
    @(posedge link_clk);
    #1;
    reg_start = 1'b0;
    n = 0;
    while (reg_done !== 1'b1 && n < 40)
    begin
      @(posedge link_clk);
      #1;
      n++;
    end
    q = reg_rdata;
    timeouts += (n >= 40);
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask : access
endmodule : link_master

// ===== sim/tb_charger_irq_mask_status_ctrl_regs.sv
// Purpose: directed register and event tests of the charger register bank
// Assumes: core clock 50 ns, link clock 160 ns at an unrelated phase
// Notes:   event inputs move just after a core edge so sync depth is predictable
module tb_charger_irq_mask_status_ctrl_regs;
  timeunit 1ns;
  timeprecision 1ns;
  logic       core_clk = 1'b0;
  logic       link_clk = 1'b0;
  logic       resetn = 1'b0;
  logic       link_resetn = 1'b0;
  logic [7:0] fault_events = 8'h00;
  logic [7:0] charge_events = 8'h00;
  logic [3:0] rail_events = 4'h0;
  logic [3:0] levels = 4'h0; // overload, discharge, thermal, battery
  logic       supply_valid = 1'b0;
  logic       uvlo = 1'b0;
  logic       reg_start, reg_write, reg_busy, reg_done, chg_int, param_reset;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [3:0] ctrl_out; // comparator, suspend, charger, boost
  logic [15:0] rst_tab [5] = '{16'h0303, 16'h04b8, 16'h05ff, 16'h0742, 16'h2000};
  int         n_fail = 0;
  int         total_checks = 0;
  int         pulses = 0;
  always #25 core_clk = ~core_clk;
  // 80 ns half period never puts a link edge on a core rising edge
  always #80 link_clk = ~link_clk;
  // counted on the falling edge so the pulse is settled when looked at
  always @(negedge core_clk) pulses += (param_reset === 1'b1);
  charger_irq_mask_status_ctrl_regs charger_irq_mask_status_ctrl_regs_inst (
    .core_clk(core_clk), .resetn(resetn), .link_clk(link_clk), .link_resetn(link_resetn),
    .reg_start(reg_start), .reg_write(reg_write), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_busy(reg_busy), .reg_done(reg_done), .reg_rdata(reg_rdata),
    .fault_events(fault_events), .charge_events(charge_events), .rail_events(rail_events),
    .rail_overload_flag(levels[3]), .discharge_limit_flag(levels[2]),
    .thermal_shutdown_flag(levels[1]), .battery_present_flag(levels[0]),
    .input_supply_valid(supply_valid), .system_rail_uvlo(uvlo),
    .comparator_enable(ctrl_out[3]), .suspend_enable(ctrl_out[2]),
    .charger_enable(ctrl_out[1]), .boost_otg_enable(ctrl_out[0]),
    .charge_param_reset(param_reset), .chg_int(chg_int));
  link_master link_master_inst (
    .link_clk(link_clk), .reg_done(reg_done), .reg_rdata(reg_rdata), .reg_start(reg_start),
    .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    link_master_inst.access(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m = 8'hff);
    logic [7:0] q;
    link_master_inst.access(1'b0, a, 8'h00, q);
    chk(q & m, exp);
  endtask : rd
  task automatic cw(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cw
  task automatic summarize;
    n_fail += link_master_inst.timeouts;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  // watchdog: the whole sequence needs well under a third of this
  initial
  begin
    #400000;
    n_fail++;
    summarize();
  end
  initial
  begin
    cw(20);
    resetn = 1'b1;
    link_resetn = 1'b1;
    foreach (rst_tab[i]) rd(rst_tab[i][15:8], rst_tab[i][7:0]);
    chk({4'h0, ctrl_out}, 8'h0a);
    wr(8'h03, 8'ha5);
    wr(8'h05, 8'hf0);
    rd(8'h03, 8'ha5);
    rd(8'h05, 8'hf0);
    $display("test reset_and_masks done");
    // masked event latches but stays quiet until unmasked
    wr(8'h03, 8'hff);
    cw(1);
    fault_events = 8'h80;
    cw(10);
    chk({7'h0, chg_int}, 8'h00);
    wr(8'h03, 8'h7f);
    cw(3);
    chk({7'h0, chg_int}, 8'h01);
    rd(8'h00, 8'h80);
    cw(3);
    chk({7'h0, chg_int}, 8'h00);
    fault_events = 8'h00;
    $display("test interrupt_mask done");
    wr(8'h07, 8'h4f);
    rd(8'h07, 8'h47);
    chk({4'h0, ctrl_out}, 8'h0f);
    chk(8'(pulses), 8'h01);
    rd(8'h05, 8'hf0);
    $display("test control done");
    wr(8'h06, 8'h00);
    for (int i = 0; i < 2; i++)
    begin
      cw(1);
      levels = i ? 4'h5 : 4'ha;
      cw(6);
      rd(8'h06, i ? 8'h0b : 8'h15, 8'h1f);
    end
    $display("test status done");
    wr(8'h07, 8'h00);
    chk({4'h0, ctrl_out}, 8'h00);
    rd(8'h06, 8'h0a, 8'h1f);
    cw(1);
    rail_events = 4'h8;
    cw(8);
    rd(8'h02, 8'h00);
    cw(1);
    rail_events = 4'h0;
    supply_valid = 1'b1;
    cw(4);
    rail_events = 4'h8;
    cw(8);
    rd(8'h02, 8'h08);
    // weak battery is a comparator event and masked at reset
    cw(1);
    charge_events = 8'h20;
    cw(8);
    chk({7'h0, chg_int}, 8'h00);
    rd(8'h01, 8'h20);
    $display("test comparator done");
    cw(1);
    uvlo = 1'b1;
    cw(12);
    chk({3'h0, chg_int, ctrl_out}, 8'h0a);
    uvlo = 1'b0;
    rd(8'h07, 8'h42);
    rd(8'h05, 8'hff);
    $display("test uvlo done");
    summarize();
  end
endmodule : tb_charger_irq_mask_status_ctrl_regs
